// ==== ccaf_cfg.svh ====
// Constants of the command interpreter: opcodes, bus map, reset values.
// Assumes inclusion by bare name from design and bench files.
`ifndef CCAF_CFG_SVH
`define CCAF_CFG_SVH

// ----------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------
`define CCAF_OP_CALSUB 32'hffffff60
`define CCAF_OP_ROTATE 32'hffffff36
`define CCAF_OP_SPINNER 32'hffffff16
`define CCAF_OP_SAVER 32'hffffff2f
`define CCAF_OP_SKETCH 32'hffffff30
`define CCAF_OP_STOP 32'hffffff17
`define CCAF_OP_SETFONT 32'hffffff2b

// ----------------------------------------------------------------
// Command lengths in words, argument limits
// ----------------------------------------------------------------
`define CCAF_LEN_CALSUB 3'h4
`define CCAF_LEN_ROTATE 3'h2
`define CCAF_LEN_SPINNER 3'h3
`define CCAF_LEN_SKETCH 3'h5
`define CCAF_LEN_SETFONT 3'h3
`define CCAF_LEN_ONE 3'h1
`define CCAF_CAL_RESULT_WORD 6'h03
`define CCAF_STYLE_MAX 16'h0003
`define CCAF_FMT_ONE_BIT_LUM 32'h00000001
`define CCAF_FMT_EIGHT_BIT_LUM 32'h00000003

// ----------------------------------------------------------------
// Animation timing in milliseconds, converted to frames at 60 frames per second
// ----------------------------------------------------------------
`define CCAF_FRAME_RATE 60
`define CCAF_PERIOD_STYLE0_MS 2000
`define CCAF_PERIOD_STYLE1_MS 1250
`define CCAF_PERIOD_STYLE3_MS 1000
`define CCAF_FRAMES(ms) 7'((ms) * `CCAF_FRAME_RATE / 1000)
`define CCAF_SAVER_MAX_X 15'h01df
`define CCAF_SAVER_MAX_Y 15'h010f

// ----------------------------------------------------------------
// Register map (byte offsets) and reset values
// ----------------------------------------------------------------
`define CCAF_REG_CTRL 9'h000
`define CCAF_REG_CMD_WRITE 9'h004
`define CCAF_REG_CMD_READ 9'h008
`define CCAF_REG_STATUS 9'h00c
`define CCAF_REG_ROTATION 9'h010
`define CCAF_FONT_BASE_BIT 7
`define CCAF_MEM_BASE_BIT 8
`define CCAF_CTRL_RESISTIVE 0
`define CCAF_CTRL_CAP_COMPAT 1
`define CCAF_CTRL_RESET 2'h1
`define CCAF_COEF_UNITY 32'h00010000
`define CCAF_VERTEX_TAG 2'h1

`endif

// ==== ccaf_pkg.sv ====
// Types of the command interpreter.
// Assumes nothing of its surroundings.
`default_nettype none
package ccaf_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CALIB = 2'b10
	} ccaf_state_t;
	typedef enum logic [3:0] {
		PM_NONE = 4'b0001,
		PM_SPIN = 4'b0010,
		PM_SAVER = 4'b0100,
		PM_SKETCH = 4'b1000
	} ccaf_pmode_t;
endpackage : ccaf_pkg
`default_nettype wire

// ==== ccaf_interp.sv ====
// Coprocessor command interpreter: calibration, rotation, periodic
// animations, touch sketch and font registration, behind AHB-Lite.
// Assumes one clock, synchronous active-low reset, frameTick and
// touchSample single-cycle pulses synchronous to mclk.
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ccaf_cfg.svh"

// Functional notes
// R01: Sub-window calibrate reads rectangle, result word
// R02: Failed calibration writes zero result word
// R03: Calibration only with resistive or compat engine
// R04: Rotate takes value 0..7 into rotation
// R05: Rotate also adjusts touch transform coefficients
// R06: Spinner reads x, y, style, scale
// R07: Spinner overlays, swaps list, runs until stop
// R08: Spinner rewrites macro slots at frame rate
// R09: Spinner period 2, 1.25, 2, 1 seconds
// R10: Scale zero means unscaled spinner
// R11: Only one periodic operation at a time
// R12: Screensaver rewrites macro slot zero per frame
// R13: Screensaver stores moving vertex point instruction
// R14: Sketch reads rectangle, bitmap base, format
// R15: Sketch format one-bit or eight-bit luminance
// R16: Sketch paints at touch sampling rate
// R17: Stop ends periodic macro or bitmap writes
// R18: Set font records handle and metrics address
// R19: Host sets up font bitmap parameters itself
// R20: Done when read pointer equals write pointer
// R21: Calibration takes three touches, loads coefficients
// R22: Decode opcode, consume arguments, then next
module ccaf_interp (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic frameTick,
	input wire logic touchSample,
	input wire logic touchPressed,
	input wire logic [15:0] touchX,
	input wire logic [15:0] touchY,
	input wire logic [4:0] fontQueryHandle,
	output logic [31:0] fontQueryAddr,
	output logic [2:0] rotation,
	output logic [31:0] touchCoefA,
	output logic [31:0] touchCoefB,
	output logic [31:0] touchCoefC,
	output logic [31:0] touchCoefD,
	output logic [31:0] touchCoefE,
	output logic [31:0] touchCoefF,
	output logic [31:0] macroSlotZero,
	output logic [31:0] macroSlotOne,
	output logic listSwap,
	output logic pixWrEn,
	output logic [31:0] pixWrAddr,
	output logic [7:0] pixWrData
);
	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic [2:0] cmdLen(input logic [31:0] op);
		unique case (op)
			`CCAF_OP_CALSUB: cmdLen = `CCAF_LEN_CALSUB;
			`CCAF_OP_ROTATE: cmdLen = `CCAF_LEN_ROTATE;
			`CCAF_OP_SPINNER: cmdLen = `CCAF_LEN_SPINNER;
			`CCAF_OP_SKETCH: cmdLen = `CCAF_LEN_SKETCH;
			`CCAF_OP_SETFONT: cmdLen = `CCAF_LEN_SETFONT;
			default: cmdLen = `CCAF_LEN_ONE;
		endcase
	endfunction : cmdLen

	function automatic logic [6:0] spinPeriod(input logic [1:0] style);
		unique case (style)
			2'h1: spinPeriod = `CCAF_FRAMES(`CCAF_PERIOD_STYLE1_MS);
			2'h3: spinPeriod = `CCAF_FRAMES(`CCAF_PERIOD_STYLE3_MS);
			default: spinPeriod = `CCAF_FRAMES(`CCAF_PERIOD_STYLE0_MS);
		endcase
	endfunction : spinPeriod

	function automatic logic [31:0] vertex(input logic [14:0] x,
		input logic [14:0] y);
		vertex = {`CCAF_VERTEX_TAG, x, y};
	endfunction : vertex

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [31:0] cmdMem [64];
	logic [31:0] fontMem [32];
	logic [31:0] argW [5];
	ccaf_pkg::ccaf_state_t stateQ, stateD;
	ccaf_pkg::ccaf_pmode_t pmQ, pmD;
	logic [5:0] wrPtrQ, wrPtrD, rdPtrQ, rdPtrD, availW;
	logic [1:0] ctrlQ, ctrlD;
	logic [2:0] rotQ, rotD;
	logic [31:0] baseQ [6];
	logic [31:0] baseD [6];
	logic [31:0] coefQ [6];
	logic [31:0] coefD [6];
	logic [31:0] macro0Q, macro0D, macro1Q, macro1D;
	logic [15:0] spXQ, spXD, spYQ, spYD, scaleQ, scaleD;
	logic [1:0] styleQ, styleD;
	logic [6:0] phaseQ, phaseD;
	logic [14:0] svXQ, svXD, svYQ, svYD;
	logic [1:0] svDirQ, svDirD;
	logic [15:0] skXQ, skXD, skYQ, skYD, skWQ, skWD, skHQ, skHD;
	logic [31:0] skPtrQ, skPtrD;
	logic skL8Q, skL8D;
	logic [15:0] calXQ, calXD, calYQ, calYD;
	logic [15:0] prvXQ, prvXD, prvYQ, prvYD, p0XQ, p0XD, p0YQ, p0YD;
	logic [1:0] calCntQ, calCntD;
	logic calFailQ, calFailD;
	logic swapQ, swapD, pixEnQ, pixEnD;
	logic [31:0] pixAddrQ, pixAddrD, fontOutQ, fontOutD;
	logic [7:0] pixDataQ, pixDataD;
	logic calWe, fontWe;
	logic [5:0] calIdx;
	logic [4:0] fontIdx;
	logic [31:0] fontVal;
	logic dpWrQ, dpWrD, readyQ, respQ;
	logic [8:0] dpAddrQ, dpAddrD;
	logic [31:0] rdataQ, rdataD;
	logic ahbTake, canRun;

	genvar k;
	for (k = 0; k < 5; k++) begin : g_arg
		assign argW[k] = cmdMem[6'(rdPtrQ + 6'(k))];
	end
	assign availW = wrPtrQ - rdPtrQ;
	assign canRun = ctrlQ[`CCAF_CTRL_RESISTIVE] |
		ctrlQ[`CCAF_CTRL_CAP_COMPAT];

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	assign ahbTake = hsel & hready & htrans[1] & (hsize == 3'h2);

	always_comb begin
		dpWrD = ahbTake & hwrite;
		dpAddrD = haddr[8:0];
		ctrlD = ctrlQ;
		wrPtrD = wrPtrQ;
		rdataD = 32'h00000000;
		if (dpWrQ && dpAddrQ == `CCAF_REG_CTRL)
			ctrlD = hwdata[1:0];
		if (dpWrQ && dpAddrQ == `CCAF_REG_CMD_WRITE)
			wrPtrD = hwdata[5:0];
		if (ahbTake && !hwrite) begin
			if (haddr[`CCAF_MEM_BASE_BIT])
				rdataD = cmdMem[haddr[7:2]];
			else if (haddr[`CCAF_FONT_BASE_BIT])
				rdataD = fontMem[haddr[6:2]];
			else unique case (haddr[8:0])
				`CCAF_REG_CTRL: rdataD = {30'h0, ctrlQ};
				`CCAF_REG_CMD_WRITE: rdataD = {26'h0, wrPtrQ};
				`CCAF_REG_CMD_READ: rdataD = {26'h0, rdPtrQ};
				`CCAF_REG_STATUS: rdataD = {27'h0, stateQ[1], pmQ};
				`CCAF_REG_ROTATION: rdataD = {29'h0, rotQ};
				default: rdataD = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Command interpreter and periodic engines
	// ----------------------------------------------------------------
	always_comb begin
		logic [2:0] len;
		logic [15:0] relX, relY;
		logic [31:0] idx, row0, row1;
		logic [22:0] off;
		len = cmdLen(argW[0]);
		relX = touchX - skXQ;
		relY = touchY - skYQ;
		idx = 32'(relY * skWQ) + 32'(relX);
		off = phaseQ * ((scaleQ == 16'h0) ? 16'h1 : scaleQ); // see R10
		row0 = 32'h0;
		row1 = 32'h0;
		stateD = stateQ;
		pmD = pmQ;
		rdPtrD = rdPtrQ;
		rotD = rotQ;
		baseD = baseQ;
		macro0D = macro0Q;
		macro1D = macro1Q;
		{spXD, spYD, scaleD, styleD, phaseD} =
			{spXQ, spYQ, scaleQ, styleQ, phaseQ};
		{svXD, svYD, svDirD} = {svXQ, svYQ, svDirQ};
		{skXD, skYD, skWD, skHD, skPtrD, skL8D} =
			{skXQ, skYQ, skWQ, skHQ, skPtrQ, skL8Q};
		{calXD, calYD, prvXD, prvYD, p0XD, p0YD, calCntD, calFailD} =
			{calXQ, calYQ, prvXQ, prvYQ, p0XQ, p0YQ, calCntQ, calFailQ};
		swapD = 1'b0;
		pixEnD = 1'b0;
		pixAddrD = pixAddrQ;
		pixDataD = pixDataQ;
		calWe = 1'b0;
		calIdx = 6'(rdPtrQ + `CCAF_CAL_RESULT_WORD);
		fontWe = 1'b0;
		fontIdx = argW[1][4:0];
		fontVal = {argW[2][31:2], 2'h0};
		fontOutD = fontMem[fontQueryHandle];
		unique case (stateQ)
			ccaf_pkg::ST_IDLE: begin
				if (availW != 6'h0 && availW >= 6'(len)) begin
					rdPtrD = 6'(rdPtrQ + 6'(len)); // see R22
					unique case (argW[0])
						`CCAF_OP_CALSUB: begin
							if (canRun) begin // see R03
								{calYD, calXD} = argW[1]; // see R01
								calCntD = 2'h0;
								calFailD = 1'b0;
								swapD = 1'b1;
								rdPtrD = rdPtrQ;
								stateD = ccaf_pkg::ST_CALIB;
							end
						end
						`CCAF_OP_ROTATE:
							rotD = argW[1][2:0]; // see R04
						`CCAF_OP_SPINNER: begin
							if (pmQ == ccaf_pkg::PM_NONE &&
								argW[2][15:0] <= `CCAF_STYLE_MAX) begin // see R06
								{spYD, spXD} = argW[1];
								styleD = argW[2][1:0];
								scaleD = argW[2][31:16];
								phaseD = 7'h0;
								swapD = 1'b1; // see R07
								pmD = ccaf_pkg::PM_SPIN; // see R11
							end
						end
						`CCAF_OP_SAVER: begin
							if (pmQ == ccaf_pkg::PM_NONE) begin
								svXD = 15'h0;
								svYD = 15'h0;
								svDirD = 2'h0;
								pmD = ccaf_pkg::PM_SAVER; // see R11
							end
						end
						`CCAF_OP_SKETCH: begin
							if (pmQ == ccaf_pkg::PM_NONE &&
								(argW[4] == `CCAF_FMT_ONE_BIT_LUM ||
								argW[4] == `CCAF_FMT_EIGHT_BIT_LUM)) begin // see R15
								{skYD, skXD} = argW[1]; // see R14
								{skHD, skWD} = argW[2];
								skPtrD = argW[3];
								skL8D = argW[4] == `CCAF_FMT_EIGHT_BIT_LUM;
								pmD = ccaf_pkg::PM_SKETCH;
							end
						end
						`CCAF_OP_STOP:
							pmD = ccaf_pkg::PM_NONE; // see R17
						`CCAF_OP_SETFONT:
							fontWe = 1'b1; // see R18
						default: ;
					endcase
				end
			end
			ccaf_pkg::ST_CALIB: begin
				if (touchSample && touchPressed) begin // see R21
					prvXD = touchX;
					prvYD = touchY;
					calCntD = 2'(calCntQ + 2'h1);
					if (calCntQ == 2'h0) begin
						p0XD = touchX;
						p0YD = touchY;
					end else if (touchX == prvXQ && touchY == prvYQ)
						calFailD = 1'b1;
					if (calCntQ == 2'h2) begin
						stateD = ccaf_pkg::ST_IDLE;
						rdPtrD = 6'(rdPtrQ + `CCAF_LEN_CALSUB);
						if (calFailD)
							calWe = 1'b1; // see R02
						else begin
							baseD[0] = `CCAF_COEF_UNITY;
							baseD[1] = 32'h0;
							baseD[2] = {16'(calXQ - p0XQ), 16'h0};
							baseD[3] = 32'h0;
							baseD[4] = `CCAF_COEF_UNITY;
							baseD[5] = {16'(calYQ - p0YQ), 16'h0};
						end
					end
				end
			end
		endcase
		// Periodic engines
		if (pmQ == ccaf_pkg::PM_SPIN && frameTick) begin // see R08
			phaseD = (phaseQ >= 7'(spinPeriod(styleQ) - 7'h1)) ?
				7'h0 : 7'(phaseQ + 7'h1); // see R09
			macro0D = vertex(15'(spXQ + 16'(off)), spYQ[14:0]);
			macro1D = {23'h0, styleQ, phaseQ};
		end
		if (pmQ == ccaf_pkg::PM_SAVER && frameTick) begin // see R12
			svXD = svDirQ[0] ? 15'(svXQ - 15'h1) : 15'(svXQ + 15'h1);
			svYD = svDirQ[1] ? 15'(svYQ - 15'h1) : 15'(svYQ + 15'h1);
			if (svXD == 15'h0 || svXD == `CCAF_SAVER_MAX_X)
				svDirD[0] = ~svDirQ[0];
			if (svYD == 15'h0 || svYD == `CCAF_SAVER_MAX_Y)
				svDirD[1] = ~svDirQ[1];
			macro0D = vertex(svXQ, svYQ); // see R13
		end
		if (pmQ == ccaf_pkg::PM_SKETCH && touchSample && touchPressed &&
			touchX >= skXQ && touchY >= skYQ &&
			relX < skWQ && relY < skHQ) begin // see R16
			pixEnD = 1'b1;
			pixAddrD = skL8Q ? skPtrQ + idx : skPtrQ + (idx >> 3);
			pixDataD = skL8Q ? 8'hff : 8'h80 >> idx[2:0]; // see R15
		end
		// Touch transform follows rotation
		for (int i = 0; i < 3; i++) begin // see R05
			row0 = rotD[0] ? 32'(-baseD[i]) : baseD[i];
			row1 = rotD[1] ? 32'(-baseD[i + 3]) : baseD[i + 3];
			coefD[i] = rotD[2] ? row1 : row0;
			coefD[i + 3] = rotD[2] ? row0 : row1;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			stateQ <= ccaf_pkg::ST_IDLE;
			pmQ <= ccaf_pkg::PM_NONE;
			{wrPtrQ, rdPtrQ, rotQ} <= '0;
			ctrlQ <= `CCAF_CTRL_RESET;
			for (int i = 0; i < 6; i++) begin
				baseQ[i] <= (i == 0 || i == 4) ? `CCAF_COEF_UNITY : 32'h0;
				coefQ[i] <= (i == 0 || i == 4) ? `CCAF_COEF_UNITY : 32'h0;
			end
			{macro0Q, macro1Q, spXQ, spYQ, scaleQ, styleQ, phaseQ} <= '0;
			{svXQ, svYQ, svDirQ} <= '0;
			{skXQ, skYQ, skWQ, skHQ, skPtrQ, skL8Q} <= '0;
			{calXQ, calYQ, prvXQ, prvYQ, p0XQ, p0YQ} <= '0;
			{calCntQ, calFailQ, swapQ, pixEnQ} <= '0;
			{pixAddrQ, pixDataQ, fontOutQ} <= '0;
			{dpWrQ, dpAddrQ, rdataQ, respQ} <= '0;
			readyQ <= 1'b1;
		end else begin
			stateQ <= stateD;
			pmQ <= pmD;
			{wrPtrQ, rdPtrQ, rotQ, ctrlQ} <= {wrPtrD, rdPtrD, rotD, ctrlD};
			baseQ <= baseD;
			coefQ <= coefD;
			{macro0Q, macro1Q} <= {macro0D, macro1D};
			{spXQ, spYQ, scaleQ, styleQ, phaseQ} <=
				{spXD, spYD, scaleD, styleD, phaseD};
			{svXQ, svYQ, svDirQ} <= {svXD, svYD, svDirD};
			{skXQ, skYQ, skWQ, skHQ, skPtrQ, skL8Q} <=
				{skXD, skYD, skWD, skHD, skPtrD, skL8D};
			{calXQ, calYQ, prvXQ, prvYQ, p0XQ, p0YQ} <=
				{calXD, calYD, prvXD, prvYD, p0XD, p0YD};
			{calCntQ, calFailQ, swapQ, pixEnQ} <=
				{calCntD, calFailD, swapD, pixEnD};
			{pixAddrQ, pixDataQ, fontOutQ} <= {pixAddrD, pixDataD, fontOutD};
			{dpWrQ, dpAddrQ, rdataQ} <= {dpWrD, dpAddrD, rdataD};
			readyQ <= 1'b1;
			respQ <= 1'b0;
		end
	end

	// Memories are not reset; host fills the command ring first
	always_ff @(posedge mclk) begin
		if (dpWrQ && dpAddrQ[`CCAF_MEM_BASE_BIT])
			cmdMem[dpAddrQ[7:2]] <= hwdata;
		if (calWe)
			cmdMem[calIdx] <= 32'h00000000;
		if (fontWe)
			fontMem[fontIdx] <= fontVal;
	end

	assign hrdata = rdataQ;
	assign hreadyout = readyQ;
	assign hresp = respQ;
	assign fontQueryAddr = fontOutQ;
	assign rotation = rotQ;
	assign {touchCoefA, touchCoefB, touchCoefC} = {coefQ[0], coefQ[1],
		coefQ[2]};
	assign {touchCoefD, touchCoefE, touchCoefF} = {coefQ[3], coefQ[4],
		coefQ[5]};
	assign macroSlotZero = macro0Q;
	assign macroSlotOne = macro1Q;
	assign listSwap = swapQ;
	assign pixWrEn = pixEnQ;
	assign pixWrAddr = pixAddrQ;
	assign pixWrData = pixDataQ;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	AST_ROTATE_TAKEN: assert property ( // see R04
		stateQ == ccaf_pkg::ST_IDLE && argW[0] == `CCAF_OP_ROTATE &&
		availW >= 6'h2 |=> rotation == $past(argW[1][2:0]))
		else $error("rotation not loaded from argument");
	AST_CALIB_GATED: assert property ( // see R03
		$rose(stateQ == ccaf_pkg::ST_CALIB) |-> $past(canRun))
		else $error("calibration entered with wrong touch engine");
	AST_FAIL_ZERO: assert property ( // see R02
		calWe |=> cmdMem[$past(calIdx)] == 32'h0 &&
		stateQ == ccaf_pkg::ST_IDLE)
		else $error("failed calibration result not zero");
	AST_ONE_PERIODIC: assert property ( // see R11
		$onehot(pmQ))
		else $error("more than one periodic operation");
	AST_STOP_HALTS: assert property ( // see R17
		stateQ == ccaf_pkg::ST_IDLE && availW != 6'h0 &&
		argW[0] == `CCAF_OP_STOP |=> pmQ == ccaf_pkg::PM_NONE ##1
		!pixWrEn)
		else $error("stop left periodic operation running");
	AST_SPIN_WRAP: assert property ( // see R09
		pmQ == ccaf_pkg::PM_SPIN |-> phaseQ < spinPeriod(styleQ))
		else $error("spinner phase beyond period");
	AST_MACRO_ON_FRAME: assert property ( // see R12
		pmQ != ccaf_pkg::PM_NONE && $changed(macroSlotZero) |->
		$past(frameTick))
		else $error("macro slot changed without frame tick");
	AST_SKETCH_L8: assert property ( // see R15
		pixWrEn && skL8Q |-> pixWrData == 8'hff &&
		$past(pmQ == ccaf_pkg::PM_SKETCH && touchSample))
		else $error("sketch pixel written out of format");
	AST_CAL_ADVANCE: assert property ( // see R20
		stateQ == ccaf_pkg::ST_CALIB |=> rdPtrQ == $past(rdPtrQ) ||
		stateQ == ccaf_pkg::ST_IDLE)
		else $error("read pointer moved during calibration");
endmodule : ccaf_interp
`default_nettype wire

// ==== ccaf_host_model.sv ====
// Host-side model: an AHB-Lite master that fills the command ring.
// Assumes one slave whose hreadyout is looped back as hready.
`timescale 1ns/100ps
`default_nettype none
`include "ccaf_cfg.svh"
module ccaf_host_model (
	input wire logic mclk,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout
);
	logic [5:0] wp = 6'h00;
	logic [31:0] rd = 32'h0;

	initial begin
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// ----------------------------------------------------------------
	// Single word transfer, entered just after a rising edge
	// ----------------------------------------------------------------
	task automatic xfer(input logic wr, input logic [31:0] a,
		input logic [31:0] wd);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : xfer

	// Results are only trusted once the ring is drained
	task automatic waitDone();
		do begin
			xfer(1'b0, 32'(`CCAF_REG_CMD_READ), 32'h0);
		end while (rd[5:0] !== wp);
	endtask : waitDone

	// Whole command into the ring, then the write pointer
	task automatic sendCmd(input logic [31:0] w [5], input int n,
		input bit hold = 1'b0);
		for (int i = 0; i < n; i++) begin
			xfer(1'b1, 32'h100 | {24'h0, wp + 6'(i), 2'b00}, w[i]);
		end
		wp = wp + 6'(n);
		xfer(1'b1, 32'(`CCAF_REG_CMD_WRITE), {26'h0, wp});
		if (!hold) begin
			waitDone();
		end
	endtask : sendCmd
endmodule : ccaf_host_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench of the command interpreter.
// Assumes the host model drives the bus; bench drives ticks and touches.
`timescale 1ns/100ps
`default_nettype none
`include "ccaf_cfg.svh"
module tb_top;
	typedef struct packed {
		logic [2:0] r;
		logic [31:0] a;
		logic [31:0] e;
	} ccaf_rot_row_t;
	localparam logic [31:0] ONE = 32'h00010000;
	localparam logic [31:0] NEG = 32'hffff0000;
	ccaf_rot_row_t rows [8] = '{'{3'h1, NEG, ONE}, '{3'h2, ONE, NEG},
		'{3'h3, NEG, NEG}, '{3'h4, 32'h0, 32'h0}, '{3'h5, 32'h0, 32'h0},
		'{3'h6, 32'h0, 32'h0}, '{3'h7, 32'h0, 32'h0}, '{3'h0, ONE, ONE}};
	int frames [4] = '{120, 75, 120, 60};
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, listSwap, pixWrEn;
	logic [31:0] haddr, hwdata, hrdata, fontQueryAddr, pixWrAddr;
	logic [1:0] htrans;
	logic [2:0] hsize, rotation;
	logic frameTick, touchSample, touchPressed;
	logic [15:0] touchX, touchY;
	logic [4:0] fontQueryHandle;
	logic [31:0] touchCoefA, touchCoefB, touchCoefC, touchCoefD;
	logic [31:0] touchCoefE, touchCoefF, macroSlotZero, macroSlotOne;
	logic [7:0] pixWrData, pixData;
	logic [31:0] pixAddr, m0;
	int pixCount = 0;
	int swapCount = 0;
	int fails = 0;
	int num_checks = 0;
	int n;

	always #2.5 mclk = ~mclk;

	ccaf_host_model host (.mclk(mclk), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout));

	ccaf_interp ccaf_interp_inst (.mclk(mclk), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .frameTick(frameTick),
		.touchSample(touchSample), .touchPressed(touchPressed),
		.touchX(touchX), .touchY(touchY), .fontQueryHandle(fontQueryHandle),
		.fontQueryAddr(fontQueryAddr), .rotation(rotation),
		.touchCoefA(touchCoefA), .touchCoefB(touchCoefB),
		.touchCoefC(touchCoefC), .touchCoefD(touchCoefD),
		.touchCoefE(touchCoefE), .touchCoefF(touchCoefF),
		.macroSlotZero(macroSlotZero), .macroSlotOne(macroSlotOne),
		.listSwap(listSwap), .pixWrEn(pixWrEn), .pixWrAddr(pixWrAddr),
		.pixWrData(pixWrData));

	// Single-cycle pulses are caught at the edge that ends them
	always @(posedge mclk) begin
		if (pixWrEn === 1'b1) begin
			pixCount <= pixCount + 1;
			pixAddr <= pixWrAddr;
			pixData <= pixWrData;
		end
		if (listSwap === 1'b1) begin
			swapCount <= swapCount + 1;
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run

	task automatic expectReg(input logic [31:0] a, input logic [31:0] e);
		host.xfer(1'b0, a, 32'h0);
		check(host.rd, e);
	endtask : expectReg

	task automatic tick(input int k);
		for (int i = 0; i < k; i++) begin
			frameTick <= 1'b1;
			@(posedge mclk);
			frameTick <= 1'b0;
			repeat (2) @(posedge mclk);
		end
	endtask : tick

	task automatic touch(input logic [15:0] x, input logic [15:0] y);
		touchX <= x;
		touchY <= y;
		touchPressed <= 1'b1;
		touchSample <= 1'b1;
		@(posedge mclk);
		touchSample <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask : touch

	task automatic stopRun();
		host.sendCmd('{`CCAF_OP_STOP, 0, 0, 0, 0}, 1);
		expectReg(32'h00c, 32'h1);
		m0 = macroSlotZero;
		tick(3);
		check(macroSlotZero, m0);
	endtask : stopRun

	// Result word is preset to a marker, then three touches follow
	task automatic calib(input logic [15:0] t [6]);
		logic [31:0] res;
		res = 32'h100 | {24'h0, host.wp + 6'h3, 2'b00};
		host.sendCmd('{`CCAF_OP_CALSUB, {16'h37, 16'h69}, {16'h28, 16'h28},
			32'h12345678, 0}, 4, 1'b1);
		// Command is taken one edge after the pointer write
		@(posedge mclk);
		expectReg(32'h00c, 32'h11);
		for (int i = 0; i < 3; i++) begin
			touch(t[2 * i], t[2 * i + 1]);
		end
		host.waitDone();
		host.xfer(1'b0, res, 32'h0);
	endtask : calib

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{frameTick, touchSample, touchPressed} = 3'h0;
		touchX = 16'h0;
		touchY = 16'h0;
		fontQueryHandle = 5'h0;
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		check(touchCoefA, ONE);
		check(macroSlotZero, 32'h0);
		expectReg(32'h000, 32'h1);
		expectReg(32'h00c, 32'h1);
		expectReg(32'h040, 32'h0);
		for (int i = 0; i < 8; i++) begin
			host.sendCmd('{`CCAF_OP_ROTATE, 32'(rows[i].r), 0, 0, 0}, 2);
			check(32'(rotation), 32'(rows[i].r));
			check(touchCoefA, rows[i].a);
			check(touchCoefE, rows[i].e);
			expectReg(32'h010, 32'(rows[i].r));
		end
		host.xfer(1'b1, 32'h000, 32'h0);
		host.sendCmd('{`CCAF_OP_CALSUB, 0, 0, 0, 0}, 4);
		expectReg(32'h00c, 32'h1);
		host.xfer(1'b1, 32'h000, 32'h1);
		calib('{16'h64, 16'h32, 16'h64, 16'h32, 16'h78, 16'h3c});
		check(host.rd, 32'h0);
		// Capacitive compatibility mode alone also allows calibration
		host.xfer(1'b1, 32'h000, 32'h2);
		calib('{16'h64, 16'h32, 16'h82, 16'h46, 16'ha0, 16'h5a});
		check(host.rd, 32'h12345678);
		check(touchCoefA, ONE);
		check(touchCoefB, 32'h0);
		check(touchCoefD, 32'h0);
		check(touchCoefC, 32'h00050000);
		check(touchCoefF, 32'h00050000);
		for (int s = 0; s < 4; s++) begin
			n = swapCount;
			host.sendCmd('{`CCAF_OP_SPINNER, {16'h14, 16'h0a},
				{16'(s), 16'(s)}, 0, 0}, 3);
			check(32'(swapCount), 32'(n + 1));
			expectReg(32'h00c, 32'h2);
			host.sendCmd('{`CCAF_OP_SAVER, 0, 0, 0, 0}, 1);
			expectReg(32'h00c, 32'h2);
			tick(1);
			m0 = macroSlotZero;
			check(32'(m0[14:0]), 32'h14);
			check(32'(macroSlotOne[8:7]), 32'(s));
			tick(frames[s]);
			check(macroSlotZero, m0);
			tick(1);
			check(32'(macroSlotZero[29:15]),
				32'(m0[29:15] + 15'((s == 0) ? 1 : s)));
			stopRun();
		end
		host.sendCmd('{`CCAF_OP_SPINNER, 0, 32'h4, 0, 0}, 3);
		expectReg(32'h00c, 32'h1);
		host.sendCmd('{`CCAF_OP_SAVER, 0, 0, 0, 0}, 1);
		tick(1);
		m0 = macroSlotZero;
		check(32'(m0[31:30]), 32'h1);
		tick(1);
		check(32'(macroSlotZero !== m0), 32'h1);
		stopRun();
		host.sendCmd('{`CCAF_OP_SKETCH, {16'h14, 16'h0a}, {16'h04, 16'h08},
			32'h1000, 32'h2}, 5);
		expectReg(32'h00c, 32'h1);
		for (int f = 0; f < 2; f++) begin
			host.sendCmd('{`CCAF_OP_SKETCH, {16'h14, 16'h0a}, {16'h04, 16'h08},
				32'h1000, f ? `CCAF_FMT_ONE_BIT_LUM : `CCAF_FMT_EIGHT_BIT_LUM}, 5);
			expectReg(32'h00c, 32'h8);
			n = pixCount;
			touch(16'h1e, 16'h16);
			touch(16'h0d, 16'h16);
			check(32'(pixCount), 32'(n + 1));
			check(pixAddr, f ? 32'h1002 : 32'h1013);
			check(32'(pixData), f ? 32'h10 : 32'hff);
			stopRun();
			touch(16'h0d, 16'h16);
			check(32'(pixCount), 32'(n + 1));
		end
		// Bitmap setup for the font is the host's own business
		host.sendCmd('{`CCAF_OP_SETFONT, 32'h1f, 32'h00012347, 0, 0}, 3);
		fontQueryHandle <= 5'h1f;
		expectReg(32'h0fc, 32'h00012344);
		check(fontQueryAddr, 32'h00012344);
		host.sendCmd('{32'hffffff99, 0, 0, 0, 0}, 1);
		expectReg(32'h008, 32'(host.wp));
		check(32'(hresp), 32'h0);
		check(32'(hreadyout), 32'h1);
		complete_run();
	end

	initial begin
		repeat (60000) @(posedge mclk);
		fails++;
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
